// ### logic/dma_channel_interrupt_logic.sv
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module dma_channel_interrupt_logic #(
    parameter int CH      = dma_irq_pkg::CHANNELS,
    parameter int COUNT_W = 24
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [31:0]   paddr,
    input  wire logic [31:0]   pwdata,
    output logic [31:0]        prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire logic [CH-1:0] xfer_req,
    input  wire logic [CH-1:0] xfer_done,
    input  wire logic [CH-1:0] src_overflow,
    input  wire logic [CH-1:0] dst_overflow,
    output logic [CH-1:0]      channel_xfer_enable,
    output logic [CH-1:0]      xfer_end_irq,
    output logic [CH-1:0]      event_irq
);
    localparam int CHW = (CH > 1) ? $clog2(CH) : 1;

    // ****************************************************************
    // Parameter checks
    // ****************************************************************
    if (CH < 2 || CH > 16) begin : g_bad_channels
        $error("Channel count must lie between 2 and 16");
    end
    if (COUNT_W < 16 || COUNT_W > 32) begin : g_bad_count
        $error("Count width must lie between 16 and 32");
    end

    // ****************************************************************
    // Register state
    // ****************************************************************
    logic [CH-1:0]      xfer_end_irq_enable;
    logic [CH-1:0]      event_irq_enable;
    logic [CH-1:0]      size_error_irq_enable;
    logic [CH-1:0]      xfer_end_flag;
    logic [CH-1:0]      event_flag;
    logic [CH-1:0]      repeat_end_irq_enable;
    logic [CH-1:0]      src_overflow_irq_enable;
    logic [CH-1:0]      dst_overflow_irq_enable;
    logic [COUNT_W-1:0] remaining_count [CH];
    logic [1:0]         mode_field      [CH];
    logic [1:0]         size_field      [CH];
    logic [7:0]         repeat_size     [CH];
    logic [15:0]        block_size      [CH];
    logic [7:0]         repeat_cnt      [CH];

    // Per-channel event outputs
    logic [COUNT_W-1:0] next_count      [CH];
    logic [CH-1:0]      counter_end;
    logic [CH-1:0]      size_error;
    logic [CH-1:0]      repeat_end;
    logic [CH-1:0]      src_event;
    logic [CH-1:0]      dst_event;

    // Derived per-channel terms
    logic [CH-1:0]      wr_mode;
    logic [CH-1:0]      wr_addr;
    logic [CH-1:0]      wr_count;
    logic [CH-1:0]      wr_config;
    logic [CH-1:0]      resume;
    logic [CH-1:0]      end_set;
    logic [CH-1:0]      event_set;
    logic [CH-1:0]      end_clear;
    logic [CH-1:0]      event_clear;
    logic [CH-1:0]      stop;

    reg_access_if #(.CHW(CHW)) ra ();

    // ****************************************************************
    // APB slave port
    // ****************************************************************
    apb_reg_port #(
        .CH  (CH),
        .CHW (CHW)
    ) u_apb (
        .pclk    (pclk),
        .presetn (presetn),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr),
        .ra      (ra.bus_side)
    );

    // Register select; the write strobe is ANDed at each use
    function automatic logic reg_hit(input logic [CHW-1:0] ch,
                                     input logic [1:0] ix, input int c,
                                     input logic [3:0] ofs);
        reg_hit = (32'(ch) == c) && (ix == ofs[3:2]);
    endfunction

    // ****************************************************************
    // Event detection, one instance per channel
    // ****************************************************************
    for (genvar c = 0; c < CH; c++) begin : g_chan
        dma_event_detect #(
            .COUNT_W (COUNT_W)
        ) u_detect (
            .mode         (mode_field[c]),
            .size         (size_field[c]),
            .block_size   (block_size[c]),
            .repeat_size  (repeat_size[c]),
            .repeat_cnt   (repeat_cnt[c]),
            .count        (remaining_count[c]),
            .enabled      (channel_xfer_enable[c]),
            .xfer_req     (xfer_req[c]),
            .xfer_done    (xfer_done[c]),
            .src_overflow (src_overflow[c]),
            .dst_overflow (dst_overflow[c]),
            .next_count   (next_count[c]),
            .counter_end  (counter_end[c]),
            .size_error   (size_error[c]),
            .repeat_end   (repeat_end[c]),
            .src_event    (src_event[c]),
            .dst_event    (dst_event[c])
        );

        assign wr_mode[c]   = ra.wr &&
            reg_hit(ra.chan, ra.idx, c, dma_irq_pkg::OFS_MODE_CONTROL);
        assign wr_addr[c]   = ra.wr &&
            reg_hit(ra.chan, ra.idx, c, dma_irq_pkg::OFS_ADDR_CONTROL);
        assign wr_count[c]  = ra.wr &&
            reg_hit(ra.chan, ra.idx, c, dma_irq_pkg::OFS_REMAINING);
        assign wr_config[c] = ra.wr &&
            reg_hit(ra.chan, ra.idx, c, dma_irq_pkg::OFS_XFER_CONFIG);

        // Enable written from 0 to 1 restarts the channel
        assign resume[c] = wr_mode[c] && !channel_xfer_enable[c] &&
                           ra.wdata[dma_irq_pkg::BIT_XFER_ENABLE];

        assign end_set[c] = counter_end[c] &&
                            xfer_end_irq_enable[c];
        assign event_set[c] =
            (size_error[c] && size_error_irq_enable[c]) ||
            (repeat_end[c] && repeat_end_irq_enable[c]) ||
            (src_event[c]  && src_overflow_irq_enable[c]) ||
            (dst_event[c]  && dst_overflow_irq_enable[c]);

        // Clear by writing zero to the flag, or by resuming
        assign end_clear[c] = resume[c] || (wr_mode[c] &&
            !ra.wdata[dma_irq_pkg::BIT_XFER_END_FLAG]);
        assign event_clear[c] = resume[c] || (wr_mode[c] &&
            !ra.wdata[dma_irq_pkg::BIT_EVENT_FLAG]);

        // A size error always halts, since the next access is impossible
        assign stop[c] = counter_end[c] || size_error[c] || event_set[c];
    end

    // ****************************************************************
    // Channel transfer enable
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            channel_xfer_enable <= '0;
        end else begin
            for (int c = 0; c < CH; c++) begin
                if (stop[c]) begin
                    channel_xfer_enable[c] <= 1'b0;
                end else if (wr_mode[c]) begin
                    channel_xfer_enable[c] <=
                        ra.wdata[dma_irq_pkg::BIT_XFER_ENABLE];
                end
            end
        end
    end

    // ****************************************************************
    // Interrupt enables
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xfer_end_irq_enable     <= '0;
            event_irq_enable        <= '0;
            size_error_irq_enable   <= '0;
            repeat_end_irq_enable   <= '0;
            src_overflow_irq_enable <= '0;
            dst_overflow_irq_enable <= '0;
        end else begin
            for (int c = 0; c < CH; c++) begin
                if (wr_mode[c]) begin
                    xfer_end_irq_enable[c] <=
                        ra.wdata[dma_irq_pkg::BIT_XFER_END_IRQ_EN];
                    event_irq_enable[c] <=
                        ra.wdata[dma_irq_pkg::BIT_EVENT_IRQ_EN];
                    size_error_irq_enable[c] <=
                        ra.wdata[dma_irq_pkg::BIT_SIZE_ERR_IRQ_EN];
                end
                if (wr_addr[c]) begin
                    repeat_end_irq_enable[c] <=
                        ra.wdata[dma_irq_pkg::BIT_REPEAT_IRQ_EN];
                    src_overflow_irq_enable[c] <=
                        ra.wdata[dma_irq_pkg::BIT_SRC_OVF_IRQ_EN];
                    dst_overflow_irq_enable[c] <=
                        ra.wdata[dma_irq_pkg::BIT_DST_OVF_IRQ_EN];
                end
            end
        end
    end

    // ****************************************************************
    // Interrupt flags
    // ****************************************************************
    // A hardware set beats a software clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xfer_end_flag <= '0;
            event_flag    <= '0;
        end else begin
            xfer_end_flag <= end_set | (xfer_end_flag & ~end_clear);
            event_flag    <= event_set | (event_flag & ~event_clear);
        end
    end

    // ****************************************************************
    // Transfer count and repeat counter
    // ****************************************************************
    // Software writes win; settings must not change mid-transfer anyway
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int c = 0; c < CH; c++) begin
                remaining_count[c] <=
                    dma_irq_pkg::REMAINING_RESET[COUNT_W-1:0];
            end
        end else begin
            for (int c = 0; c < CH; c++) begin
                if (wr_count[c]) begin
                    remaining_count[c] <= ra.wdata[COUNT_W-1:0];
                end else if (xfer_done[c] && channel_xfer_enable[c]) begin
                    remaining_count[c] <= next_count[c];
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int c = 0; c < CH; c++) begin
                repeat_cnt[c] <= 8'h00;
            end
        end else begin
            for (int c = 0; c < CH; c++) begin
                if (wr_config[c] || repeat_end[c]) begin
                    repeat_cnt[c] <= 8'h00;
                end else if (xfer_done[c] && channel_xfer_enable[c] &&
                             mode_field[c] ==
                             2'(dma_irq_pkg::MODE_REPEAT) &&
                             repeat_cnt[c] != repeat_size[c]) begin
                    repeat_cnt[c] <= repeat_cnt[c] + 8'h01;
                end
            end
        end
    end

    // ****************************************************************
    // Transfer configuration
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int c = 0; c < CH; c++) begin
                mode_field[c]  <= dma_irq_pkg::XFER_CONFIG_RESET[
                    dma_irq_pkg::POS_MODE +: 2];
                size_field[c]  <= dma_irq_pkg::XFER_CONFIG_RESET[
                    dma_irq_pkg::POS_SIZE +: 2];
                repeat_size[c] <= dma_irq_pkg::XFER_CONFIG_RESET[
                    dma_irq_pkg::POS_REPEAT_SIZE +: 8];
                block_size[c]  <= dma_irq_pkg::XFER_CONFIG_RESET[
                    dma_irq_pkg::POS_BLOCK_SIZE +: 16];
            end
        end else begin
            for (int c = 0; c < CH; c++) begin
                if (wr_config[c]) begin
                    mode_field[c]  <= ra.wdata[dma_irq_pkg::POS_MODE +: 2];
                    size_field[c]  <= ra.wdata[dma_irq_pkg::POS_SIZE +: 2];
                    repeat_size[c] <=
                        ra.wdata[dma_irq_pkg::POS_REPEAT_SIZE +: 8];
                    block_size[c]  <=
                        ra.wdata[dma_irq_pkg::POS_BLOCK_SIZE +: 16];
                end
            end
        end
    end

    // ****************************************************************
    // Interrupt requests
    // ****************************************************************
    // Plain levels per channel; the interrupt controller picks among them
    assign xfer_end_irq = xfer_end_flag & xfer_end_irq_enable;
    assign event_irq    = event_flag & event_irq_enable;

    // ****************************************************************
    // Read mux
    // ****************************************************************
    always_comb begin
        int c;
        c = 32'(ra.chan);
        ra.rdata = 32'h0000_0000;
        if (c < CH) begin
            unique case (ra.idx)
                dma_irq_pkg::OFS_MODE_CONTROL[3:2]: begin
                    ra.rdata[dma_irq_pkg::BIT_XFER_ENABLE] =
                        channel_xfer_enable[c];
                    ra.rdata[dma_irq_pkg::BIT_XFER_END_IRQ_EN] =
                        xfer_end_irq_enable[c];
                    ra.rdata[dma_irq_pkg::BIT_EVENT_IRQ_EN] =
                        event_irq_enable[c];
                    ra.rdata[dma_irq_pkg::BIT_SIZE_ERR_IRQ_EN] =
                        size_error_irq_enable[c];
                    ra.rdata[dma_irq_pkg::BIT_XFER_END_FLAG] =
                        xfer_end_flag[c];
                    ra.rdata[dma_irq_pkg::BIT_EVENT_FLAG] = event_flag[c];
                    ra.rdata[dma_irq_pkg::BIT_XFER_END_IRQ] =
                        xfer_end_irq[c];
                    ra.rdata[dma_irq_pkg::BIT_EVENT_IRQ] = event_irq[c];
                end
                dma_irq_pkg::OFS_ADDR_CONTROL[3:2]: begin
                    ra.rdata[dma_irq_pkg::BIT_REPEAT_IRQ_EN] =
                        repeat_end_irq_enable[c];
                    ra.rdata[dma_irq_pkg::BIT_SRC_OVF_IRQ_EN] =
                        src_overflow_irq_enable[c];
                    ra.rdata[dma_irq_pkg::BIT_DST_OVF_IRQ_EN] =
                        dst_overflow_irq_enable[c];
                end
                dma_irq_pkg::OFS_REMAINING[3:2]: begin
                    ra.rdata[COUNT_W-1:0] = remaining_count[c];
                end
                dma_irq_pkg::OFS_XFER_CONFIG[3:2]: begin
                    ra.rdata[dma_irq_pkg::POS_MODE +: 2] = mode_field[c];
                    ra.rdata[dma_irq_pkg::POS_SIZE +: 2] = size_field[c];
                    ra.rdata[dma_irq_pkg::POS_REPEAT_SIZE +: 8] =
                        repeat_size[c];
                    ra.rdata[dma_irq_pkg::POS_BLOCK_SIZE +: 16] =
                        block_size[c];
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ### logic/dma_irq_pkg.sv
`default_nettype none
package dma_irq_pkg;

    // ****************************************************************
    // Register map, one 16-byte window per channel
    // ****************************************************************
    localparam int          CHANNELS         = 4;
    localparam int          CHAN_WINDOW_BITS = 4;
    localparam logic [3:0]  OFS_MODE_CONTROL = 4'h0;
    localparam logic [3:0]  OFS_ADDR_CONTROL = 4'h4;
    localparam logic [3:0]  OFS_REMAINING    = 4'h8;
    localparam logic [3:0]  OFS_XFER_CONFIG  = 4'hc;

    // Mode and control register fields
    localparam int BIT_XFER_ENABLE     = 0;
    localparam int BIT_XFER_END_IRQ_EN = 1;
    localparam int BIT_EVENT_IRQ_EN    = 2;
    localparam int BIT_SIZE_ERR_IRQ_EN = 3;
    localparam int BIT_XFER_END_FLAG   = 8;
    localparam int BIT_EVENT_FLAG      = 9;
    localparam int BIT_XFER_END_IRQ    = 16;
    localparam int BIT_EVENT_IRQ       = 17;

    // Address control register fields
    localparam int BIT_REPEAT_IRQ_EN   = 0;
    localparam int BIT_SRC_OVF_IRQ_EN  = 1;
    localparam int BIT_DST_OVF_IRQ_EN  = 2;

    // Transfer configuration register fields
    localparam int POS_MODE        = 0;
    localparam int POS_SIZE        = 2;
    localparam int POS_REPEAT_SIZE = 8;
    localparam int POS_BLOCK_SIZE  = 16;

    // Reset values
    localparam logic [31:0] MODE_CONTROL_RESET = 32'h0000_0000;
    localparam logic [31:0] ADDR_CONTROL_RESET = 32'h0000_0000;
    localparam logic [31:0] REMAINING_RESET    = 32'h0000_0000;
    localparam logic [31:0] XFER_CONFIG_RESET  = 32'h0000_0000;

    typedef enum logic [1:0] {
        MODE_NORMAL,
        MODE_REPEAT,
        MODE_BLOCK
    } xfer_mode_e;

    // Bytes moved by one access; the unused code falls back to a byte
    function automatic logic [2:0] access_bytes(input logic [1:0] size);
        unique case (size)
            2'h1:    access_bytes = 3'h2;
            2'h2:    access_bytes = 3'h4;
            default: access_bytes = 3'h1;
        endcase
    endfunction

endpackage
`default_nettype wire

// ### logic/reg_access_if.sv
`timescale 1ns/10ps
`default_nettype none
interface reg_access_if #(
    parameter int CHW = 2
);
    logic           wr;
    logic [CHW-1:0] chan;
    logic [1:0]     idx;
    logic [31:0]    wdata;
    logic [31:0]    rdata;

    modport bus_side (output wr, output chan, output idx, output wdata,
                      input rdata);
    modport reg_side (input wr, input chan, input idx, input wdata,
                      output rdata);
endinterface
`default_nettype wire

// ### logic/apb_reg_port.sv
`timescale 1ns/10ps
`default_nettype none
module apb_reg_port #(
    parameter int CH  = 4,
    parameter int CHW = 2
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    reg_access_if.bus_side   ra
);
    localparam int LOW = dma_irq_pkg::CHAN_WINDOW_BITS;

    logic hit;

    // Unmapped: upper bits set, channel out of range or misaligned
    assign hit = (paddr[31:LOW+CHW] == '0) &&
                 (32'(paddr[LOW+CHW-1:LOW]) < CH) &&
                 (paddr[1:0] == 2'h0);

    assign ra.chan  = paddr[LOW+CHW-1:LOW];
    assign ra.idx   = paddr[3:2];
    assign ra.wdata = pwdata;
    assign ra.wr    = psel && penable && pwrite && hit;

    // Zero wait states: every access phase completes at once
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !hit;

    // Read data is captured in the setup cycle so it is a flop output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= hit ? ra.rdata : 32'h0000_0000;
        end
    end
endmodule
`default_nettype wire

// ### logic/dma_event_detect.sv
`timescale 1ns/10ps
`default_nettype none
module dma_event_detect #(
    parameter int COUNT_W = 24
) (
    input  wire logic [1:0]         mode,
    input  wire logic [1:0]         size,
    input  wire logic [15:0]        block_size,
    input  wire logic [7:0]         repeat_size,
    input  wire logic [7:0]         repeat_cnt,
    input  wire logic [COUNT_W-1:0] count,
    input  wire logic               enabled,
    input  wire logic               xfer_req,
    input  wire logic               xfer_done,
    input  wire logic               src_overflow,
    input  wire logic               dst_overflow,
    output logic [COUNT_W-1:0]      next_count,
    output logic                    counter_end,
    output logic                    size_error,
    output logic                    repeat_end,
    output logic                    src_event,
    output logic                    dst_event
);
    logic [COUNT_W-1:0] unit;
    logic               is_block;
    logic               is_repeat;

    assign is_block  = mode == 2'(dma_irq_pkg::MODE_BLOCK);
    assign is_repeat = mode == 2'(dma_irq_pkg::MODE_REPEAT);

    // Block mode moves a whole block per request
    assign unit = is_block ? COUNT_W'(block_size) :
                  COUNT_W'(dma_irq_pkg::access_bytes(size));

    assign next_count  = (count >= unit) ? count - unit : count;
    assign counter_end = enabled && xfer_done && (next_count == '0);

    // A request that cannot be served by what is left over
    assign size_error = enabled && xfer_req && (count < unit);

    // Fires only when a repeat area is set up (repeat size not zero)
    assign repeat_end = enabled && xfer_req && is_repeat &&
                        (repeat_size != 8'h00) &&
                        (repeat_cnt == repeat_size);

    assign src_event = enabled && xfer_done && src_overflow;
    assign dst_event = enabled && xfer_done && dst_overflow;
endmodule
`default_nettype wire

// ### bench/irq_ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none
module irq_ctrl_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [3:0] xfer_end_irq,
    input  wire logic [3:0] event_irq,
    output var  logic [3:0] pending
);
    // Each channel latched on its own; priority is settled further on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            pending <= '0;
        else
            pending <= xfer_end_irq | event_irq;
    end
endmodule
`default_nettype wire

// ### bench/dma_irq_chk.sv
`timescale 1ns/10ps
`default_nettype none
module dma_irq_chk #(parameter int CH = 4) (
    input wire logic          pclk,
    input wire logic          presetn,
    input wire logic          psel,
    input wire logic          penable,
    input wire logic          pwrite,
    input wire logic [31:0]   paddr,
    input wire logic          pslverr,
    input wire logic [CH-1:0] xfer_req,
    input wire logic [CH-1:0] xfer_done,
    input wire logic [CH-1:0] channel_xfer_enable,
    input wire logic [CH-1:0] xfer_end_irq,
    input wire logic [CH-1:0] event_irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic wr = psel && penable && pwrite;
    // ****************************************************************
    // Software writes are the only other cause of an output change
    // ****************************************************************
    slverr_decode_a: assert property (pslverr == (psel && penable &&
        (paddr[31:6] != 0 || paddr[1:0] != 0))) else $error("bad pslverr");
    end_cause_a: assert property ($rose(xfer_end_irq[0])
        && !$past(wr) |-> $past(xfer_done[0] && channel_xfer_enable[0])
        && !channel_xfer_enable[0]) else $error("end irq without cause");
    event_cause_a: assert property ($rose(event_irq[0])
        && !$past(wr) |->
        $past(channel_xfer_enable[0] && (xfer_req[0] || xfer_done[0]))
        && !channel_xfer_enable[0]) else $error("event irq without cause");
    end_drop_a: assert property ($fell(xfer_end_irq[0]) |->
        $past(wr)) else $error("end irq dropped alone");
    event_drop_a: assert property ($fell(event_irq[0]) |-> $past(wr))
        else $error("event irq dropped alone");
    enable_set_a: assert property ($rose(channel_xfer_enable[0]) |->
        $past(wr)) else $error("enable set without write");
    idle_quiet_a: assert property (!channel_xfer_enable[0] && !wr |=>
        $stable(xfer_end_irq[0]) && $stable(event_irq[0]))
        else $error("irq moved while channel idle");
    chan_apart_a: assert property ($rose(xfer_end_irq[1])
        && !$past(wr) |-> $past(xfer_done[1]))
        else $error("channel 1 end irq no cause");
endmodule
bind dma_channel_interrupt_logic dma_irq_chk #(.CH(CH)) dma_irq_chk_i (.*);
`default_nettype wire

// ### bench/dma_channel_interrupt_logic_tb.sv
`timescale 1ns/10ps
`default_nettype none
module dma_channel_interrupt_logic_tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic [3:0]  xfer_req, xfer_done, src_overflow, dst_overflow, pending;
    logic [3:0]  channel_xfer_enable, xfer_end_irq, event_irq;
    int          error_cnt, n_compared;
    dma_channel_interrupt_logic dma_channel_interrupt_logic_i (.*);
    irq_ctrl_model irq_ctrl_model_i (.pclk(pclk), .presetn(presetn),
        .xfer_end_irq(xfer_end_irq), .event_irq(event_irq), .pending(pending));
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    // Whole run is well under 1000 cycles
    initial begin
        #200_000;
        error_cnt++;
        tally_and_finish();
    end
    task automatic chk(input string n, input logic [31:0] s, e);
        n_compared++;
        if (s !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic apb(input logic w, input logic [31:0] a, d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic ev(input logic [15:0] v);
        @(posedge pclk);
        {xfer_req, xfer_done, src_overflow, dst_overflow} <= v;
        @(posedge pclk);
        {xfer_req, xfer_done, src_overflow, dst_overflow} <= '0;
        @(posedge pclk);
    endtask
    task automatic setup(input int c, input logic [31:0] cf, rem, ac, mc);
        apb(1'b1, c * 16 + 12, cf);
        apb(1'b1, c * 16 + 8, rem);
        apb(1'b1, c * 16 + 4, ac);
        apb(1'b1, c * 16, mc);
    endtask
    task automatic t_reset();
        apb(1'b0, 32'h0000_0000, 32'h0000_0000);
        chk("mode_ctl_reset", rd, 32'h0000_0000);
        apb(1'b0, 32'h0000_0040, 32'h0000_0000);
        chk("unmapped_err", 32'(err), 32'h0000_0001);
        chk("pready", 32'(pready), 32'h0000_0001);
    endtask
    task automatic t_end();
        for (int c = 0; c < 4; c++) begin
            setup(c, 32'h0000_0000, 32'h0000_0001, 32'h0000_0000,
                  32'h0000_0003);
            ev(16'(1 << (c + 8)));
            chk("end_irq", 32'(xfer_end_irq), 32'(1 << c));
            chk("enable", 32'(channel_xfer_enable), 32'h0000_0000);
            apb(1'b0, c * 16, 32'h0000_0000);
            chk("mode_ctl", rd, 32'h0001_0102);
            chk("pending", 32'(pending), 32'(1 << c));
            apb(1'b1, c * 16, 32'h0000_0002);
            @(negedge pclk);
            chk("end_irq_clr", 32'(xfer_end_irq), 32'h0000_0000);
        end
    endtask
    task automatic t_size();
        setup(0, 32'h0008_0002, 32'h0000_0004, 32'h0000_0000, 32'h0000_000d);
        ev(16'h1000);
        chk("block_size_err", 32'(event_irq), 32'h0000_0001);
        setup(0, 32'h0000_0008, 32'h0000_0002, 32'h0000_0000, 32'h0000_0009);
        ev(16'h1000);
        chk("masked_event", 32'(event_irq), 32'h0000_0000);
        apb(1'b0, 32'h0000_0000, 32'h0000_0000);
        chk("size_err_flag", rd, 32'h0000_0208);
        setup(1, 32'h0000_0000, 32'h0000_0001, 32'h0000_0000, 32'h0000_0001);
        ev(16'h0200);
        apb(1'b0, 32'h0000_0010, 32'h0000_0000);
        chk("end_masked", rd, 32'h0000_0000);
    endtask
    task automatic t_repeat();
        setup(0, 32'h0000_0201, 32'h0000_0010, 32'h0000_0001, 32'h0000_0005);
        ev(16'h0100);
        ev(16'h0100);
        chk("repeat_early", 32'(event_irq), 32'h0000_0000);
        ev(16'h1000);
        chk("repeat_end", 32'(event_irq), 32'h0000_0001);
    endtask
    task automatic t_ovf();
        logic [31:0] ac[3] = '{32'h0000_0002, 32'h0000_0004, 32'h0000_0004};
        logic [15:0] v[3] = '{16'h0110, 16'h0101, 16'h0110};
        logic [31:0] e[3] = '{32'h0000_0001, 32'h0000_0001, 32'h0000_0000};
        for (int i = 0; i < 3; i++) begin
            setup(0, 32'h0000_0000, 32'h0000_0010, ac[i], 32'h0000_0005);
            ev(v[i]);
            chk("overflow", 32'(event_irq), e[i]);
        end
    endtask
    task automatic tally_and_finish();
        $display("mismatches %0d comparisons %0d", error_cnt, n_compared);
        if (error_cnt == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {xfer_req, xfer_done, src_overflow, dst_overflow} = '0;
        error_cnt = 0;
        n_compared = 0;
        presetn = 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_end();
        t_size();
        t_repeat();
        t_ovf();
        tally_and_finish();
    end
endmodule
`default_nettype wire
